//--- serial_ctrl_pkg.sv
package serial_ctrl_pkg;

  // ***************************************************************
  // Register map (byte offsets on APB)
  // ***************************************************************
  localparam logic [11:0] OFS_DATA = 12'h000; // serial_data_buffer
  localparam logic [11:0] OFS_CTL1 = 12'h004; // serial_control_one
  localparam logic [11:0] OFS_CTL2 = 12'h008; // serial_control_two
  localparam logic [11:0] OFS_FLAGS = 12'h00c; // serial_flags

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int C1_RX9 = 7; // rx_ninth_bit
  localparam int C1_TX9 = 6; // tx_ninth_bit
  localparam int C1_LEN9 = 4; // char_len9
  localparam int C1_WAKE = 3; // wake_addr_mode
  localparam int C2_TIE = 7; // tx_empty_irq_en
  localparam int C2_TX_DONE_IRQ_EN = 6; // tx_done_irq_en
  localparam int C2_RIE = 5; // rx_full_irq_en
  localparam int C2_LINE_QUIET_IRQ_EN = 4; // line_quiet_irq_en
  localparam int C2_TE = 3; // tx_enable
  localparam int C2_RE = 2; // rx_enable
  localparam int C2_RWU = 1; // rx_standby
  localparam int C2_SBK = 0; // send_break_ctl

  // ***************************************************************
  // Reset values and timing counts
  // ***************************************************************
  localparam logic [7:0] CTL2_RST = 8'h00; // All enables off
  localparam logic TX_BUFFER_EMPTY_FLAG_RST = 1'b1; // Buffer empty at reset
  localparam logic TC_RST = 1'b1; // Nothing shifting at reset
  localparam logic [3:0] OS_PER_BIT = 4'hf; // Last of 16 samples per bit
  localparam logic [3:0] SMP_A = 4'h6; // First noise-check sample
  localparam logic [3:0] SMP_B = 4'h7; // Second noise-check sample
  localparam logic [3:0] SMP_C = 4'h8; // Third sample, decision point
  localparam logic [3:0] LEN8 = 4'ha; // Frame bits, 8-bit characters
  localparam logic [3:0] LEN9 = 4'hb; // Frame bits, 9-bit characters

  // Status flags in register bit order (bit 0 reserved)
  typedef struct packed {
    logic tx_buffer_empty_flag; // tx_buffer_empty_flag
    logic tc; // tx_done_flag
    logic rx_buffer_full_flag; // rx_buffer_full_flag
    logic idle; // line quiet flag
    logic ovr; // overrun flag
    logic nf; // noise_flag
    logic fe; // frame_error_flag
    logic rsv; // Reads zero
  } flags_s;

endpackage

//--- async_serial_ctrl_status.sv
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Length bit picks 9 or 8 bits
// - Wake bit: address mark or idle line
// - Tx empty enable gates empty flag
// - Tx done enable gates done flag
// - Rx enable gates full or overrun
// - Quiet enable gates idle flag
// - Tx enable sends preamble of ones
// - Rx enable off keeps flags intact
// - Standby until selected wake condition
// - Break sends zero groups, then one
// - Empty flag: set on load, cleared
// - Done flag: set when all quiet
// - Full flag: set on char, cleared
// - Idle flag after ten/eleven ones
// - Overrun keeps old char, sets flag
// - Noise flag follows buffered character
// - Frame error on zero stop bit
// - Overrun suppresses frame error flag
// - Sixteen samples per bit, noise check
// - Ninth bit captured with data
module async_serial_ctrl_status #(
  parameter int OS_DIV = 16 // Clocks per sixteenth of a bit
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rst, // Sync reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic serial_in_pin, // Receive pin
  output logic serial_out_pin, // Transmit pin level
  output logic serial_out_oe_n, // Transmit pin drive, low drives
  output logic irq // Interrupt request
);
  import serial_ctrl_pkg::*;

  typedef enum logic [0:0] {RX_WAIT, RX_BITS} rx_state_e;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0] ctl2_r; // serial_control_two
  logic len9_r; // Character length select
  logic wake_r; // Wakeup method select
  logic rx9_r; // rx_ninth_bit
  logic tx9_r; // tx_ninth_bit
  logic [7:0] txbuf_r; // Transmit buffer
  logic [7:0] rxbuf_r; // Receive buffer
  flags_s flg_r; // Status flags, assembled for reads
  logic tx_buffer_empty_flag_r, tc_r; // Transmit flags, one writer each
  logic rx_buffer_full_flag_r, idle_r, ovr_r, nf_r, fe_r; // Receive flags
  logic pready_r; // Ready to pins
  logic [31:0] prdata_r; // Read data to pins
  logic pslverr_r; // Error to pins
  logic irq_r; // Request to pin
  logic arm_tx_buffer_empty_flag_r, arm_tc_r; // Status seen with tx flags set
  logic arm_rx_buffer_full_flag_r, arm_idle_r, arm_ovr_r, arm_rx_r; // Status seen
  logic [7:0] os_div_r; // Sixteenth-bit divider
  logic os_tick; // Sixteenth-bit strobe
  logic [3:0] tx_os_r; // Tx sixteenths within bit
  logic bit_tick; // Tx bit strobe
  logic [10:0] tx_sh_r; // Tx shift register, LSB out
  logic [3:0] tx_cnt_r; // Tx bits left in frame
  logic pre_pend_r; // Preamble still owed
  logic brk_tail_r; // One owed after break
  logic te_q_r; // Tx enable last cycle
  logic quiet_q_r; // Tx quiet last cycle
  logic sin_m_r, sin_r; // Input synchroniser
  rx_state_e rx_st_r; // Receiver state
  logic [3:0] rx_os_r; // Rx sixteenths within bit
  logic [3:0] rx_idx_r; // Rx bit index, 0 = start
  logic [1:0] smp_r; // Earlier noise-check samples
  logic [8:0] rx_sh_r; // Rx shift register
  logic nz_r; // Noise seen in frame
  logic [7:0] hi_cnt_r; // Sixteenths of line high
  logic quiet_arm_r; // Line went low since last idle

  // ***************************************************************
  // APB decode
  // ***************************************************************
  logic acc_end, wr_end, rd_end; // Completing transfer
  logic mapped; // Address hits a register
  logic [3:0] len; // Frame length in bits
  assign acc_end = psel & penable & pready_r;
  assign wr_end = acc_end & pwrite;
  assign rd_end = acc_end & ~pwrite;
  assign mapped = (paddr == OFS_DATA) | (paddr == OFS_CTL1) |
                  (paddr == OFS_CTL2) | (paddr == OFS_FLAGS);
  assign len = len9_r ? LEN9 : LEN8;

  // Ready one cycle into access so read data comes from a flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (psel & penable & ~pready_r & ~pwrite) begin
        unique case (paddr)
          OFS_DATA: prdata_r <= {24'h0, rxbuf_r};
          OFS_CTL1: prdata_r <= {24'h0, rx9_r, tx9_r, 1'b0, len9_r, wake_r, 3'h0};
          OFS_CTL2: prdata_r <= {24'h0, ctl2_r};
          OFS_FLAGS: prdata_r <= {24'h0, flg_r};
          default: prdata_r <= 32'h0; // Unmapped reads zero
        endcase
      end
    end
  end

  // Length, wake and tx ninth bit survive reset by design
  always_ff @(posedge mclk) begin
    if (wr_end && paddr == OFS_CTL1) begin
      len9_r <= pwdata[C1_LEN9];
      wake_r <= pwdata[C1_WAKE];
      tx9_r <= pwdata[C1_TX9];
    end
  end

  // Wake condition hardware-clears standby; a write wins over it
  logic char_done, msb_one, idle_evt, wake_hit; // Receiver events
  assign wake_hit = ctl2_r[C2_RWU] &
                    (wake_r ? (char_done & msb_one) : idle_evt);
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl2_r <= CTL2_RST;
    end else if (wr_end && paddr == OFS_CTL2) begin
      ctl2_r <= pwdata[7:0];
    end else if (wake_hit) begin
      ctl2_r[C2_RWU] <= 1'b0;
    end
  end

  // Transmit buffer takes every data write
  always_ff @(posedge mclk) begin
    if (rst) begin
      txbuf_r <= 8'h0;
    end else if (wr_end && paddr == OFS_DATA) begin
      txbuf_r <= pwdata[7:0];
    end
  end

  // Status read arms clearing of the flags then set
  logic st_rd, dat_rd, dat_wr; // Register accesses
  assign st_rd = rd_end & (paddr == OFS_FLAGS);
  assign dat_rd = rd_end & (paddr == OFS_DATA);
  assign dat_wr = wr_end & (paddr == OFS_DATA);
  always_ff @(posedge mclk) begin
    if (rst | dat_rd | dat_wr) begin
      arm_tx_buffer_empty_flag_r <= 1'b0;
      arm_tc_r <= 1'b0;
      arm_rx_buffer_full_flag_r <= (rst | dat_rd) ? 1'b0 : arm_rx_buffer_full_flag_r;
      arm_idle_r <= (rst | dat_rd) ? 1'b0 : arm_idle_r;
      arm_ovr_r <= (rst | dat_rd) ? 1'b0 : arm_ovr_r;
      arm_rx_r <= (rst | dat_rd) ? 1'b0 : arm_rx_r;
    end else if (st_rd) begin
      arm_tx_buffer_empty_flag_r <= flg_r.tx_buffer_empty_flag;
      arm_tc_r <= flg_r.tc;
      arm_rx_buffer_full_flag_r <= flg_r.rx_buffer_full_flag;
      arm_idle_r <= flg_r.idle;
      arm_ovr_r <= flg_r.ovr;
      arm_rx_r <= 1'b1; // Noise and frame flags need no set state
    end
  end

  // ***************************************************************
  // Bit-rate timing
  // ***************************************************************
  // Shared sixteenth-bit strobe, like the common baud generator
  always_ff @(posedge mclk) begin
    if (rst || os_div_r == 8'(OS_DIV - 1)) begin
      os_div_r <= 8'h0;
    end else begin
      os_div_r <= os_div_r + 8'h1;
    end
  end
  assign os_tick = (os_div_r == 8'(OS_DIV - 1));
  assign bit_tick = os_tick & (tx_os_r == OS_PER_BIT);

  // Tx bit clock free-runs at sixteen sixteenths
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_os_r <= 4'h0;
    end else if (os_tick) begin
      tx_os_r <= tx_os_r + 4'h1;
    end
  end

  // ***************************************************************
  // Transmitter
  // ***************************************************************
  logic tx_next; // Frame boundary reached
  logic tx_load; // Buffer moves to shift register
  logic tx_quiet; // Nothing shifting or owed
  assign tx_next = bit_tick & (tx_cnt_r <= 4'h1);
  assign tx_load = tx_next & ctl2_r[C2_TE] & ~pre_pend_r & ~ctl2_r[C2_SBK] &
                   ~brk_tail_r & ~flg_r.tx_buffer_empty_flag;
  assign tx_quiet = (tx_cnt_r == 4'h0) & ~pre_pend_r & ~brk_tail_r &
                    ~ctl2_r[C2_SBK];

  // Rising enable owes a preamble; a dropped enable forgets it
  always_ff @(posedge mclk) begin
    if (rst) begin
      te_q_r <= 1'b0;
      pre_pend_r <= 1'b0;
    end else begin
      te_q_r <= ctl2_r[C2_TE];
      if (ctl2_r[C2_TE] & ~te_q_r) begin
        pre_pend_r <= 1'b1;
      end else if (tx_next | ~ctl2_r[C2_TE]) begin
        pre_pend_r <= 1'b0;
      end
    end
  end

  // Frame loader: preamble, break, closing one, then data
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= 4'h0;
      brk_tail_r <= 1'b0;
    end else if (tx_next && pre_pend_r) begin
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= len;
    end else if (tx_next && ctl2_r[C2_SBK]) begin
      tx_sh_r <= 11'h000;
      tx_cnt_r <= len;
      brk_tail_r <= 1'b1;
    end else if (tx_next && brk_tail_r) begin
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= 4'h1;
      brk_tail_r <= 1'b0;
    end else if (tx_load) begin
      tx_sh_r <= len9_r ? {1'b1, tx9_r, txbuf_r, 1'b0} : {2'b11, txbuf_r, 1'b0};
      tx_cnt_r <= len;
    end else if (tx_next) begin
      tx_cnt_r <= 4'h0; // Idle high between frames
    end else if (bit_tick) begin
      tx_sh_r <= {1'b1, tx_sh_r[10:1]};
      tx_cnt_r <= tx_cnt_r - 4'h1;
    end
  end

  // Pin idles high; released once disabled and quiet
  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_out_pin <= 1'b1;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_pin <= (tx_cnt_r != 4'h0) ? tx_sh_r[0] : 1'b1;
      serial_out_oe_n <= ~(ctl2_r[C2_TE] | (tx_cnt_r != 4'h0));
    end
  end

  // Transmit flags; a set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_buffer_empty_flag_r <= TX_BUFFER_EMPTY_FLAG_RST;
      tc_r <= TC_RST;
      quiet_q_r <= 1'b1;
    end else begin
      quiet_q_r <= tx_quiet & flg_r.tx_buffer_empty_flag;
      if (tx_load) begin
        tx_buffer_empty_flag_r <= 1'b1;
      end else if (dat_wr & arm_tx_buffer_empty_flag_r) begin
        tx_buffer_empty_flag_r <= 1'b0;
      end
      if (tx_quiet & flg_r.tx_buffer_empty_flag & ~quiet_q_r) begin
        tc_r <= 1'b1;
      end else if (dat_wr & arm_tc_r) begin
        tc_r <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Receiver
  // ***************************************************************
  // Pin crosses two flops before anything looks at it
  always_ff @(posedge mclk) begin
    if (rst) begin
      sin_m_r <= 1'b1;
      sin_r <= 1'b1;
    end else begin
      sin_m_r <= serial_in_pin;
      sin_r <= sin_m_r;
    end
  end

  logic smp_now, bit_val, bit_nz; // Decision sample and vote
  logic [3:0] stop_idx; // Index of stop bit
  assign smp_now = os_tick & (rx_os_r == SMP_C);
  assign bit_val = (smp_r[0] & smp_r[1]) | (smp_r[0] & sin_r) | (smp_r[1] & sin_r);
  assign bit_nz = ~((smp_r[0] == smp_r[1]) & (smp_r[1] == sin_r));
  assign stop_idx = len - 4'h1;
  assign char_done = (rx_st_r == RX_BITS) & smp_now & (rx_idx_r == stop_idx);
  assign msb_one = rx_sh_r[8];

  // Sixteen sixteenths per bit, majority of three at mid-bit
  always_ff @(posedge mclk) begin
    if (rst || !ctl2_r[C2_RE]) begin
      rx_st_r <= RX_WAIT;
      rx_os_r <= 4'h0;
      rx_idx_r <= 4'h0;
      nz_r <= 1'b0;
    end else if (os_tick) begin
      unique case (rx_st_r)
        RX_WAIT: begin
          rx_os_r <= 4'h0;
          rx_idx_r <= 4'h0;
          nz_r <= 1'b0;
          if (!sin_r) begin
            rx_st_r <= RX_BITS; // Low line level seen
          end
        end
        RX_BITS: begin
          rx_os_r <= rx_os_r + 4'h1;
          if (rx_os_r == OS_PER_BIT) begin
            rx_idx_r <= rx_idx_r + 4'h1;
          end
          if (rx_os_r == SMP_C) begin
            nz_r <= nz_r | bit_nz;
            if ((rx_idx_r == 4'h0 && bit_val) || rx_idx_r == stop_idx) begin
              rx_st_r <= RX_WAIT; // False start or frame end
            end
          end
        end
      endcase
    end
  end

  // Noise-check samples and data shifting
  always_ff @(posedge mclk) begin
    if (rst) begin
      smp_r <= 2'b11;
      rx_sh_r <= 9'h0;
    end else begin
      if (os_tick && rx_os_r == SMP_A) begin
        smp_r[0] <= sin_r;
      end
      if (os_tick && rx_os_r == SMP_B) begin
        smp_r[1] <= sin_r;
      end
      if (rx_st_r == RX_BITS && smp_now && rx_idx_r != 4'h0 && rx_idx_r != stop_idx) begin
        rx_sh_r <= {bit_val, rx_sh_r[8:1]};
      end
    end
  end

  // Line-high count; idle once per quiet spell after activity
  logic [7:0] idle_len; // Sixteenths in a full idle character
  assign idle_len = {len, 4'h0};
  assign idle_evt = ctl2_r[C2_RE] & os_tick & quiet_arm_r & (hi_cnt_r == idle_len - 8'h1);
  always_ff @(posedge mclk) begin
    if (rst || !sin_r || !ctl2_r[C2_RE]) begin
      hi_cnt_r <= 8'h0;
      quiet_arm_r <= ~rst & ~sin_r;
    end else if (os_tick) begin
      hi_cnt_r <= hi_cnt_r + 8'h1;
      if (idle_evt) begin
        quiet_arm_r <= 1'b0;
      end
    end
  end

  // Character lands unless overrun; standby drops non-waking ones
  logic take_char; // Character enters the buffer
  assign take_char = char_done & ~flg_r.rx_buffer_full_flag & (~ctl2_r[C2_RWU] | wake_hit);
  always_ff @(posedge mclk) begin
    if (take_char) begin
      rxbuf_r <= len9_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
      rx9_r <= len9_r ? rx_sh_r[8] : rx9_r;
    end
  end

  // Receive flags; set beats the clearing data read
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_buffer_full_flag_r <= 1'b0;
      idle_r <= 1'b0;
      ovr_r <= 1'b0;
      nf_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      if (take_char) begin
        rx_buffer_full_flag_r <= 1'b1;
        nf_r <= nz_r | bit_nz;
        fe_r <= ~bit_val;
      end else if (dat_rd) begin
        rx_buffer_full_flag_r <= flg_r.rx_buffer_full_flag & ~arm_rx_buffer_full_flag_r;
        nf_r <= flg_r.nf & ~arm_rx_r;
        fe_r <= flg_r.fe & ~arm_rx_r;
      end
      if (char_done & flg_r.rx_buffer_full_flag) begin
        ovr_r <= 1'b1;
      end else if (dat_rd & arm_ovr_r) begin
        ovr_r <= 1'b0;
      end
      if (idle_evt) begin
        idle_r <= 1'b1;
      end else if (dat_rd & arm_idle_r) begin
        idle_r <= 1'b0;
      end
    end
  end
  // Register bit order, bit 0 reads zero
  assign flg_r = {tx_buffer_empty_flag_r, tc_r, rx_buffer_full_flag_r, idle_r, ovr_r, nf_r, fe_r, 1'b0};

  // ***************************************************************
  // Interrupt request
  // ***************************************************************
  // Receiver sources mute while disabled or in standby
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (ctl2_r[C2_TIE] & flg_r.tx_buffer_empty_flag) |
               (ctl2_r[C2_TX_DONE_IRQ_EN] & flg_r.tc) |
               (ctl2_r[C2_RE] & ~ctl2_r[C2_RWU] &
                ((ctl2_r[C2_RIE] & (flg_r.rx_buffer_full_flag | flg_r.ovr)) |
                 (ctl2_r[C2_LINE_QUIET_IRQ_EN] & flg_r.idle)));
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  tx_empty_irq_a: assert property (@(posedge mclk) disable iff (rst)
    ctl2_r[C2_TIE] && flg_r.tx_buffer_empty_flag |=> irq) else $error("empty flag did not raise irq");
  tx_done_irq_a: assert property (@(posedge mclk) disable iff (rst)
    ctl2_r[C2_TX_DONE_IRQ_EN] && flg_r.tc |=> irq) else $error("done flag did not raise irq");
  rx_ovr_irq_a: assert property (@(posedge mclk) disable iff (rst)
    ctl2_r[C2_RE] && !ctl2_r[C2_RWU] && ctl2_r[C2_RIE] && flg_r.ovr |=> irq)
    else $error("overrun did not raise irq");
  rx_off_mute_a: assert property (@(posedge mclk) disable iff (rst)
    !ctl2_r[C2_RE] && !ctl2_r[C2_TIE] && !ctl2_r[C2_TX_DONE_IRQ_EN] |=> !irq)
    else $error("irq while receiver disabled");
  ovr_keeps_char_a: assert property (@(posedge mclk) disable iff (rst)
    char_done && flg_r.rx_buffer_full_flag |=> $stable(rxbuf_r) && flg_r.ovr)
    else $error("overrun changed buffered character");
  fe_under_ovr_a: assert property (@(posedge mclk) disable iff (rst)
    char_done && flg_r.rx_buffer_full_flag |=> flg_r.fe == $past(flg_r.fe))
    else $error("frame error set with overrun");
  tx_buffer_empty_flag_on_load_a: assert property (@(posedge mclk) disable iff (rst)
    tx_load |=> flg_r.tx_buffer_empty_flag && tx_cnt_r == len && tx_sh_r[0] == 1'b0)
    else $error("load did not set empty flag");
  break_zeros_a: assert property (@(posedge mclk) disable iff (rst)
    tx_next && !pre_pend_r && ctl2_r[C2_SBK] |=> tx_sh_r == 11'h000 ##1 !serial_out_pin)
    else $error("break group not all zero");
  preamble_a: assert property (@(posedge mclk) disable iff (rst)
    tx_next && pre_pend_r |=> tx_cnt_r == len && tx_sh_r == 11'h7ff)
    else $error("preamble not all ones");

endmodule // async_serial_ctrl_status

//--- remote_serial_model.sv
`timescale 1ns/1ps
// ***************************************************************
// Remote transceiver facing the serial pins
// ***************************************************************
module remote_serial_model #(
  parameter int BIT_CLKS = 16 // Clocks per bit time
) (
  input wire logic mclk, // Shared time base
  input wire logic tx_line, // Line from the block
  output logic rx_line // Line into the block
);
  initial rx_line = 1'b1; // Idle is mark, the pulled-up level

  // One 8-bit frame, LSB first; stop_ok low forces a zero stop bit
  // Noisy flips bit 1 for one clock at its first noise-check sample
  task automatic send(input logic [7:0] b, input logic stop_ok, input logic noisy = 1'b0);
    logic [9:0] f;
    f = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      rx_line <= f[i];
      if (noisy && i == 1) begin
        repeat (7) @(posedge mclk);
        rx_line <= ~f[i];
        @(posedge mclk);
        rx_line <= f[i];
        repeat (BIT_CLKS - 9) @(posedge mclk);
      end else begin
        repeat (BIT_CLKS - 1) @(posedge mclk);
      end
    end
    @(posedge mclk);
    rx_line <= 1'b1; // Released line returns to mark
  endtask

  // Takes one frame off the line, sampled mid-bit
  task automatic recv(output logic [7:0] b);
    @(negedge tx_line);
    repeat (BIT_CLKS / 2 + BIT_CLKS) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      b[i] = tx_line;
      repeat (BIT_CLKS) @(posedge mclk);
    end
  endtask
endmodule // remote_serial_model

//--- async_serial_ctrl_status_tb.sv
`timescale 1ns/1ps
module async_serial_ctrl_status_tb;
  import serial_ctrl_pkg::*;
  localparam int BITC = 16; // Clocks per bit with one clock per sixteenth
  typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] m; logic [7:0] e;
    logic q;} row_s;
  logic mclk, rst, psel, penable, pwrite, serial_in_pin, serial_out_pin, oe_n, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic [7:0] rb;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // Plain rows: register, written value, read mask, expected read, irq
  row_s rows [8] = '{'{OFS_CTL1, 8'h58, 8'h7f, 8'h58, 1'b0}, '{OFS_CTL1, 8'h00, 8'h7f, 8'h00, 1'b0},
    '{OFS_CTL2, 8'h80, 8'hff, 8'h80, 1'b1}, '{OFS_CTL2, 8'h40, 8'hff, 8'h40, 1'b1},
    '{OFS_CTL2, 8'h20, 8'hff, 8'h20, 1'b0}, '{OFS_CTL2, 8'h10, 8'hff, 8'h10, 1'b0},
    '{12'h010, 8'hff, 8'hff, 8'h00, 1'b0}, '{OFS_CTL2, 8'h00, 8'hff, 8'h00, 1'b0}};

  async_serial_ctrl_status #(.OS_DIV(1)) DUT (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe_n(oe_n), .irq(irq));
  remote_serial_model #(.BIT_CLKS(BITC)) far (.mclk(mclk), .tx_line(serial_out_pin),
    .rx_line(serial_in_pin));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Hang guard, far above the few thousand cycles the tests take
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // Reset values: enables clear, both transmit flags set
    apb(0, OFS_CTL2, 0); chk("ctl2 reset", rd, 32'h0);
    apb(0, OFS_FLAGS, 0); chk("flags reset", rd, 32'hc0);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].w);
      repeat (3) @(posedge mclk);
      chk("irq", irq, rows[i].q);
      apb(0, rows[i].a, 0);
      chk("reg", rd & {24'h0, rows[i].m}, rows[i].e);
      chk("slverr", er, rows[i].a == 12'h010);
    end
    $display("register rows done");
    // Software clears both transmit flags before enabling
    apb(0, OFS_FLAGS, 0); apb(1, OFS_DATA, 8'h3c);
    apb(0, OFS_FLAGS, 0); chk("tx flags cleared", rd & 32'hc0, 32'h0);
    apb(1, OFS_CTL2, 8'h08);
    repeat (9 * BITC) @(posedge mclk);
    chk("preamble", {oe_n, serial_out_pin}, 2'b01);
    far.recv(rb); chk("tx byte", rb, 8'h3c);
    repeat (3 * BITC) @(posedge mclk);
    apb(0, OFS_FLAGS, 0); chk("tx flags set", rd & 32'hc0, 32'hc0);
    $display("transmit test done");
    apb(1, OFS_CTL2, 8'h09);
    repeat (25 * BITC) @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      repeat (4 * BITC) @(posedge mclk);
      chk("break low", serial_out_pin, 1'b0);
    end
    apb(1, OFS_CTL2, 8'h08);
    repeat (12 * BITC) @(posedge mclk);
    chk("break end", serial_out_pin, 1'b1);
    $display("break test done");
    // Reception, idle flag, receiver switched off with flags held
    apb(1, OFS_CTL2, 8'h24);
    far.send(8'ha5, 1'b1);
    repeat (4) @(posedge mclk);
    chk("rx irq", irq, 1'b1);
    repeat (12 * BITC) @(posedge mclk);
    apb(1, OFS_CTL2, 8'h00);
    repeat (3) @(posedge mclk);
    chk("irq off", irq, 1'b0);
    apb(0, OFS_FLAGS, 0); chk("rx flags", rd & 32'h3e, 32'h30);
    apb(0, OFS_DATA, 0); chk("rx byte", rd, 32'ha5);
    apb(0, OFS_FLAGS, 0); chk("rx cleared", rd & 32'h3e, 32'h0);
    // Overrun with a bad stop bit, then a framing error alone
    apb(1, OFS_CTL2, 8'h04);
    far.send(8'h11, 1'b1);
    far.send(8'h22, 1'b0);
    repeat (4) @(posedge mclk);
    apb(0, OFS_FLAGS, 0); chk("overrun", rd & 32'h2e, 32'h28);
    apb(0, OFS_DATA, 0); chk("old byte", rd, 32'h11);
    far.send(8'h33, 1'b0);
    repeat (4) @(posedge mclk);
    apb(0, OFS_FLAGS, 0); chk("frame err", rd & 32'h2e, 32'h22);
    apb(0, OFS_DATA, 0);
    $display("receive tests done");
    // Address-mark standby: plain byte dropped, marked byte wakes
    apb(1, OFS_CTL1, 8'h08);
    apb(1, OFS_CTL2, 8'h06);
    far.send(8'h44, 1'b1);
    repeat (4) @(posedge mclk);
    apb(0, OFS_FLAGS, 0); chk("standby drop", rd & 32'h20, 32'h0);
    far.send(8'hc4, 1'b1);
    repeat (4) @(posedge mclk);
    apb(0, OFS_CTL2, 0); chk("woken", rd, 32'h04);
    apb(0, OFS_FLAGS, 0);
    apb(0, OFS_DATA, 0); chk("wake byte", rd, 32'hc4);
    $display("standby test done");
    // One disagreeing sample: noise flag, majority keeps the data
    far.send(8'h55, 1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    apb(0, OFS_FLAGS, 0); chk("noise", rd & 32'h2e, 32'h24);
    apb(0, OFS_DATA, 0); chk("noisy byte", rd, 32'h55);
    apb(0, OFS_FLAGS, 0); chk("noise cleared", rd & 32'h2e, 32'h0);
    $display("noise test done");
    final_report();
  end
endmodule // async_serial_ctrl_status_tb
